/* pkg/i2c_master_defs.svh */
// offsets, field positions, reset values and timing for the two-wire master
`ifndef I2C_MASTER_DEFS_SVH
`define I2C_MASTER_DEFS_SVH
// register offsets in the special-function space
`define ADDR_SLAVE_ADDRESS_DIRECTION 16'hff80
`define ADDR_PRIMARY_WRITE_BYTE      16'hff81
`define ADDR_SECONDARY_WRITE_BYTE    16'hff82
`define ADDR_PRIMARY_READ_BYTE       16'hff83
`define ADDR_SECONDARY_READ_BYTE     16'hff84
`define ADDR_TRANSFER_CONTROL_STATUS 16'hff85
`define ADDR_INT_GROUP_SIX_CONTROL   16'hff95
// field positions
`define DIRECTION_BIT_POS            0
`define TWO_BYTE_SELECT_POS          0
`define TRANSFER_START_BUSY_POS      1
`define ACK_ERROR_FLAG_POS           2
`define TRANSFER_DONE_FLAG_POS       2
`define TRANSFER_DONE_ENABLE_POS     3
// reset values
`define RESET_BYTE                   8'h00
// timing: core rate, bit rate, quarter-bit count
`define CORE_CLK_HZ                  200000000
`define BUS_BIT_HZ                   400000
`define QUARTER_CYCLES               (`CORE_CLK_HZ / (`BUS_BIT_HZ * 4))
`define QUARTER_CNT_W                7
`endif

/* pkg/i2c_master_pkg.sv */
// types shared by the two-wire master design
package i2c_master_pkg;
  // gray-coded transaction states along the usual path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_ADDR  = 3'b011,
    ST_AACK  = 3'b010,
    ST_DATA  = 3'b110,
    ST_DACK  = 3'b111,
    ST_STOP  = 3'b101,
    ST_DONE  = 3'b100
  } xfer_state_t;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] sfr_addr_t;
endpackage : i2c_master_pkg

/* rtl/serial_two_wire_master.sv */
// two-wire bus master with special-function register port
`include "i2c_master_defs.svh"
`timescale 1ns/1ps
module serial_two_wire_master (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_n,
  input  wire i2c_master_pkg::sfr_addr_t  i_sfr_addr,
  input  wire logic                       i_sfr_wr,
  input  wire logic                       i_sfr_rd,
  input  wire i2c_master_pkg::byte_t      i_sfr_wdata,
  output i2c_master_pkg::byte_t           o_sfr_rdata,
  output logic                            o_ext_int6,
  input  wire logic                       i_scl,
  output logic                            o_scl,
  output logic                            o_scl_oe_n,
  input  wire logic                       i_sda,
  output logic                            o_sda,
  output logic                            o_sda_oe_n
);
  import i2c_master_pkg::*;

  byte_t       addr_dir_q;
  byte_t       wr_pri_q;
  byte_t       wr_sec_q;
  byte_t       rd_pri_q;
  byte_t       rd_sec_q;
  logic        two_byte_q;
  logic        busy_q;
  logic        ack_err_q;
  logic        done_flag_q;
  logic        done_en_q;
  byte_t       rdata_q;
  logic        int_q;
  xfer_state_t state_q, state_d;
  logic [1:0]  phase_q, phase_d;
  logic [`QUARTER_CNT_W-1:0] qcnt_q;
  byte_t       shift_q, shift_d;
  logic [2:0]  bitcnt_q, bitcnt_d;
  logic        byte_idx_q, byte_idx_d;
  logic        ack_q, ack_d;
  logic        scl_rel_q, scl_rel_d;
  logic        sda_rel_q, sda_rel_d;
  logic        set_err;
  logic        cap_pri;
  logic        cap_sec;
  logic        pop;
  logic [1:0]  push_cnt_q;
  logic        buf_in_ready;
  logic        buf_out_valid;
  byte_t       buf_out_data;

  // register decode
  wire sel_dar  = (i_sfr_addr == `ADDR_SLAVE_ADDRESS_DIRECTION);
  wire sel_wdr  = (i_sfr_addr == `ADDR_PRIMARY_WRITE_BYTE);
  wire sel_secondary_write_byte = (i_sfr_addr == `ADDR_SECONDARY_WRITE_BYTE);
  wire sel_rdr  = (i_sfr_addr == `ADDR_PRIMARY_READ_BYTE);
  wire sel_secondary_read_byte = (i_sfr_addr == `ADDR_SECONDARY_READ_BYTE);
  wire sel_csr  = (i_sfr_addr == `ADDR_TRANSFER_CONTROL_STATUS);
  wire sel_int6 = (i_sfr_addr == `ADDR_INT_GROUP_SIX_CONTROL);
  // setup writes other than the interrupt enable are ignored while a transaction runs
  wire wr_ok    = i_sfr_wr & ~busy_q;
  wire start_go = wr_ok & sel_csr
                & i_sfr_wdata[`TRANSFER_START_BUSY_POS];
  wire is_read  = addr_dir_q[`DIRECTION_BIT_POS];
  wire last_byte = (byte_idx_q == two_byte_q);

  // status and control read-back
  wire byte_t csr_view = {5'h00, ack_err_q, busy_q, two_byte_q};
  wire byte_t int6_view = {4'h0, done_en_q, done_flag_q, 2'h0};
  wire byte_t rd_mux =
      sel_dar  ? addr_dir_q :
      sel_wdr  ? wr_pri_q   :
      sel_secondary_write_byte ? wr_sec_q   :
      sel_rdr  ? rd_pri_q   :
      sel_secondary_read_byte ? rd_sec_q   :
      sel_csr  ? csr_view   :
      sel_int6 ? int6_view  : 8'h00;

  // quarter-bit enable from the core clock divider
  wire tick = (qcnt_q == `QUARTER_CNT_W'(`QUARTER_CYCLES - 1));

  // wait while the slave holds the clock low, or for a write byte
  wire next_data = (state_q == ST_AACK) ? ~ack_q : ~last_byte;
  wire need_byte = ((state_q == ST_AACK) || (state_q == ST_DACK))
                 & (phase_q == 2'd3) & ~is_read & next_data
                 & ~((state_q == ST_DACK) & ack_q);
  wire stretch = (phase_q == 2'd2) & scl_rel_q & ~i_scl
               & (state_q != ST_START) & (state_q != ST_IDLE);
  wire step = tick & ~stretch & ~(need_byte & ~buf_out_valid);

  // outgoing bytes queued at start, primary first
  wire   buf_in_valid = (push_cnt_q != 2'd0);
  wire byte_t buf_in_data = (push_cnt_q == 2'd2 || !two_byte_q)
                          ? wr_pri_q : wr_sec_q;
  wire   buf_flush = (state_q == ST_DONE);

  two_entry_buffer #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_tx_buffer (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_flush     (buf_flush),
    .i_in_valid  (buf_in_valid),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (buf_in_data),
    .o_out_valid (buf_out_valid),
    .i_out_ready (pop),
    .o_out_data  (buf_out_data)
  );

  // bus sequencer, advanced one quarter bit per step
  always_comb begin
    state_d    = state_q;
    phase_d    = phase_q;
    shift_d    = shift_q;
    bitcnt_d   = bitcnt_q;
    byte_idx_d = byte_idx_q;
    ack_d      = ack_q;
    scl_rel_d  = scl_rel_q;
    sda_rel_d  = sda_rel_q;
    set_err    = 1'b0;
    cap_pri    = 1'b0;
    cap_sec    = 1'b0;
    pop        = 1'b0;
    if (state_q == ST_DONE) begin
      state_d = ST_IDLE;
    end else if (start_go) begin
      state_d    = ST_START;
      phase_d    = 2'd0;
      byte_idx_d = 1'b0;
    end else if (step) begin
      phase_d = phase_q + 2'd1;
      case (state_q)
        ST_START: begin
          case (phase_q)
            2'd0: begin
              scl_rel_d = 1'b1;
              sda_rel_d = 1'b1;
            end
            2'd2: sda_rel_d = 1'b0;
            2'd3: begin
              scl_rel_d = 1'b0;
              shift_d   = addr_dir_q;
              bitcnt_d  = 3'd7;
              state_d   = ST_ADDR;
            end
            default: ;
          endcase
        end
        ST_ADDR, ST_DATA: begin
          case (phase_q)
            2'd0: sda_rel_d = (state_q == ST_DATA && is_read)
                            ? 1'b1 : shift_q[7];
            2'd1: scl_rel_d = 1'b1;
            2'd2: shift_d = {shift_q[6:0], i_sda};
            default: begin
              scl_rel_d = 1'b0;
              bitcnt_d  = bitcnt_q - 3'd1;
              if (bitcnt_q == 3'd0) begin
                state_d = (state_q == ST_ADDR) ? ST_AACK : ST_DACK;
              end
            end
          endcase
        end
        ST_AACK, ST_DACK: begin
          case (phase_q)
            2'd0: begin
              sda_rel_d = 1'b1;
              if (state_q == ST_DACK && is_read) begin
                sda_rel_d = last_byte; // nack ends the read
                cap_pri   = ~byte_idx_q;
                cap_sec   = byte_idx_q;
              end
            end
            2'd1: scl_rel_d = 1'b1;
            2'd2: ack_d = i_sda & ~(state_q == ST_DACK && is_read);
            default: begin
              scl_rel_d = 1'b0;
              bitcnt_d  = 3'd7;
              if (ack_q) begin
                set_err = 1'b1;
                state_d = ST_STOP;
              end else if (state_q == ST_DACK && last_byte) begin
                state_d = ST_STOP;
              end else begin
                state_d = ST_DATA;
                if (state_q == ST_DACK) begin
                  byte_idx_d = 1'b1;
                end
                if (!is_read) begin
                  pop     = 1'b1;
                  shift_d = buf_out_data;
                end
              end
            end
          endcase
        end
        ST_STOP: begin
          case (phase_q)
            2'd0: sda_rel_d = 1'b0;
            2'd1: scl_rel_d = 1'b1;
            2'd2: sda_rel_d = 1'b1;
            default: state_d = ST_DONE;
          endcase
        end
        default: phase_d = 2'd0;
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q    <= ST_IDLE;
      phase_q    <= 2'd0;
      shift_q    <= `RESET_BYTE;
      bitcnt_q   <= 3'd0;
      byte_idx_q <= 1'b0;
      ack_q      <= 1'b0;
      scl_rel_q  <= 1'b1;
      sda_rel_q  <= 1'b1;
    end else begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      shift_q    <= shift_d;
      bitcnt_q   <= bitcnt_d;
      byte_idx_q <= byte_idx_d;
      ack_q      <= ack_d;
      scl_rel_q  <= scl_rel_d;
      sda_rel_q  <= sda_rel_d;
    end
  end

  // quarter-bit divider, restarted with each transaction
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || start_go || state_q == ST_IDLE || tick) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= qcnt_q + `QUARTER_CNT_W'(1);
    end
  end

  // setup registers written by software
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      addr_dir_q <= `RESET_BYTE;
      wr_pri_q   <= `RESET_BYTE;
      wr_sec_q   <= `RESET_BYTE;
      two_byte_q <= 1'b0;
      done_en_q  <= 1'b0;
    end else begin
      if (wr_ok && sel_dar)  addr_dir_q <= i_sfr_wdata;
      if (wr_ok && sel_wdr)  wr_pri_q   <= i_sfr_wdata;
      if (wr_ok && sel_secondary_write_byte) wr_sec_q   <= i_sfr_wdata;
      if (wr_ok && sel_csr) begin
        two_byte_q <= i_sfr_wdata[`TWO_BYTE_SELECT_POS];
      end
      if (i_sfr_wr && sel_int6) begin
        done_en_q <= i_sfr_wdata[`TRANSFER_DONE_ENABLE_POS];
      end
    end
  end

  // busy, ack error and done flag
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      busy_q      <= 1'b0;
      ack_err_q   <= 1'b0;
      done_flag_q <= 1'b0;
    end else if (start_go) begin
      busy_q      <= 1'b1;
      ack_err_q   <= 1'b0;
      done_flag_q <= 1'b0;
    end else begin
      if (state_q == ST_DONE) begin
        busy_q      <= 1'b0;
        done_flag_q <= 1'b1;
      end
      if (set_err) begin
        ack_err_q <= 1'b1;
      end
    end
  end

  // queue write bytes into the buffer after start
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || buf_flush) begin
      push_cnt_q <= 2'd0;
    end else if (start_go) begin
      push_cnt_q <= is_read ? 2'd0
                  : (i_sfr_wdata[`TWO_BYTE_SELECT_POS] ? 2'd2 : 2'd1);
    end else if (buf_in_valid && buf_in_ready) begin
      push_cnt_q <= push_cnt_q - 2'd1;
    end
  end

  // received bytes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rd_pri_q <= `RESET_BYTE;
      rd_sec_q <= `RESET_BYTE;
    end else begin
      if (cap_pri) rd_pri_q <= shift_q;
      if (cap_sec) rd_sec_q <= shift_q;
    end
  end

  // registered read data and interrupt
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_q <= `RESET_BYTE;
      int_q   <= 1'b0;
    end else begin
      if (i_sfr_rd) rdata_q <= rd_mux;
      int_q <= done_flag_q & done_en_q;
    end
  end

  // open-drain pins: value low, enable low pulls the wire
  assign o_sfr_rdata = rdata_q;
  assign o_ext_int6  = int_q;
  assign o_scl       = 1'b0;
  assign o_sda       = 1'b0;
  assign o_scl_oe_n  = scl_rel_q;
  assign o_sda_oe_n  = sda_rel_q;
endmodule : serial_two_wire_master

/* rtl/two_entry_buffer.sv */
// two-entry valid/ready buffer for outgoing data bytes
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  wire              push = i_in_valid & o_in_ready;
  wire              pop  = o_out_valid & i_out_ready;

  // honest full and empty from the occupancy count
  assign o_in_ready  = (count_q != (PW+1)'(DEPTH));
  assign o_out_valid = (count_q != '0);
  assign o_out_data  = mem_q[rd_ptr_q];

  // storage
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : two_entry_buffer

/* sim/serial_two_wire_master_properties.sv */
// port-level checks for the two-wire master
`timescale 1ns/1ps
module serial_two_wire_master_properties (
  input wire logic                      i_core_clk,
  input wire logic                      i_rst_n,
  input wire i2c_master_pkg::sfr_addr_t i_sfr_addr,
  input wire logic                      i_sfr_wr,
  input wire logic                      i_sfr_rd,
  input wire i2c_master_pkg::byte_t     i_sfr_wdata,
  input wire i2c_master_pkg::byte_t     o_sfr_rdata,
  input wire logic                      o_ext_int6,
  input wire logic                      i_scl,
  input wire logic                      o_scl,
  input wire logic                      o_scl_oe_n,
  input wire logic                      i_sda,
  input wire logic                      o_sda,
  input wire logic                      o_sda_oe_n
);
  import i2c_master_pkg::*;
  logic        scl_prev_q;
  logic [11:0] gap_q;
  logic        en_q;
  // cycles between clock pull-downs, and a shadow of the enable bit
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      scl_prev_q <= 1'b1;
      gap_q      <= 12'hfff;
      en_q       <= 1'b0;
    end else begin
      scl_prev_q <= o_scl_oe_n;
      if (scl_prev_q && !o_scl_oe_n) gap_q <= 12'h001;
      else if (gap_q != 12'hfff) gap_q <= gap_q + 12'h001;
      if (i_sfr_wr && i_sfr_addr == 16'hff95) en_q <= i_sfr_wdata[3];
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // bit spacing within a frame
  property p_bit_period;
    scl_prev_q && !o_scl_oe_n |-> gap_q == 12'h1f4 || gap_q > 12'h258;
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("bit gap");
  property p_scl_low;
    $fell(o_scl_oe_n) |-> ##250 $rose(o_scl_oe_n);
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("low phase");
  // start then clock low one quarter later
  property p_start_form;
    $fell(o_sda_oe_n) && o_scl_oe_n |-> ##125 $fell(o_scl_oe_n);
  endproperty
  a_start_form: assert property (p_start_form) else $error("start");
  property p_stop_form;
    $rose(o_sda_oe_n) && o_scl_oe_n |->
      $past(o_scl_oe_n, 125) && !$past(o_scl_oe_n, 126);
  endproperty
  a_stop_form: assert property (p_stop_form) else $error("stop");
  property p_int_rise;
    $rose(o_sda_oe_n) && o_scl_oe_n && en_q |-> ##[100:200] o_ext_int6;
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("no irq");
  property p_int_idle;
    o_ext_int6 |-> o_scl_oe_n && o_sda_oe_n;
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("irq busy");
  property p_int_drop;
    i_sfr_wr && i_sfr_addr == 16'hff85 && i_sfr_wdata[1] |->
      ##3 !o_ext_int6 [*8];
  endproperty
  a_int_drop: assert property (p_int_drop) else $error("irq kept");
  property p_int_masked;
    !$past(en_q) |-> !o_ext_int6;
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("masked");
  property p_busy_read;
    i_sfr_rd && i_sfr_addr == 16'hff85 && !o_scl_oe_n |=> o_sfr_rdata[1];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy");
  property p_read_hold;
    !i_sfr_rd |=> $stable(o_sfr_rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("rdata");
endmodule : serial_two_wire_master_properties

bind serial_two_wire_master serial_two_wire_master_properties
  serial_two_wire_master_properties_i (.i_core_clk, .i_rst_n, .i_sfr_addr,
  .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .o_ext_int6, .i_scl,
  .o_scl, .o_scl_oe_n, .i_sda, .o_sda, .o_sda_oe_n);

/* sim/serial_two_wire_master_tb_top.sv */
// self-checking bench for the two-wire master
`timescale 1ns/1ps
module serial_two_wire_master_tb_top;
  import i2c_master_pkg::*;
  logic      i_core_clk, i_rst_n, i_sfr_wr, i_sfr_rd;
  sfr_addr_t i_sfr_addr;
  byte_t     i_sfr_wdata, o_sfr_rdata, rd0, rd1, got_a, got0, got1, v;
  logic      o_ext_int6, o_scl, o_scl_oe_n, o_sda, o_sda_oe_n;
  logic      scl_w, sda_w, slv_oe_n, nack;
  int        miscompares, checks;
  sfr_addr_t ra [8] = '{16'hff80, 16'hff81, 16'hff82, 16'hff83,
                        16'hff84, 16'hff85, 16'hff95, 16'hff86};
  // pulled-up bus wires
  assign scl_w = o_scl_oe_n ? 1'b1 : o_scl;
  assign sda_w = (o_sda_oe_n ? 1'b1 : o_sda) & slv_oe_n;
  serial_two_wire_master serial_two_wire_master_i (.i_core_clk, .i_rst_n,
    .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
    .o_ext_int6, .i_scl(scl_w), .o_scl, .o_scl_oe_n, .i_sda(sda_w), .o_sda,
    .o_sda_oe_n);
  two_wire_slave_model two_wire_slave_model_i (.i_scl(scl_w),
    .i_sda(sda_w), .i_nack(nack), .i_rd0(rd0), .i_rd1(rd1),
    .o_sda_oe_n(slv_oe_n), .o_got_addr(got_a), .o_got0(got0),
    .o_got1(got1));
  // 200 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk_val(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic wr(input sfr_addr_t a, input byte_t d);
    @(negedge i_core_clk);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    @(negedge i_core_clk);
    i_sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input sfr_addr_t a, output byte_t d);
    @(negedge i_core_clk);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    @(negedge i_core_clk);
    i_sfr_rd = 1'b0;
    @(negedge i_core_clk);
    d = o_sfr_rdata;
  endtask : rd
  task automatic chk_reg(input sfr_addr_t a, input byte_t exp);
    byte_t d;
    rd(a, d);
    chk_val(d, exp);
  endtask : chk_reg
  // poll the busy bit, bounded
  task automatic wait_done;
    for (int n = 0; n < 8000; n++) begin
      rd(16'hff85, v);
      if (v[1] !== 1'b1) break;
    end
    chk_val({7'h00, v[1]}, 8'h00);
  endtask : wait_done
  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end
  initial begin
    {i_rst_n, i_sfr_wr, i_sfr_rd, nack} = 4'h0;
    i_sfr_addr = 16'h0000;
    i_sfr_wdata = 8'h00;
    rd0 = 8'h96;
    rd1 = 8'h5a;
    miscompares = 0;
    checks = 0;
    repeat (10) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    foreach (ra[i]) chk_reg(ra[i], 8'h00);
    // two-byte write, enable on, write refused while busy
    wr(16'hff95, 8'h08);
    wr(16'hff80, 8'ha4);
    wr(16'hff81, 8'h3c);
    wr(16'hff82, 8'hc5);
    wr(16'hff85, 8'h03);
    chk_reg(16'hff85, 8'h03);
    wr(16'hff81, 8'h77);
    chk_reg(16'hff81, 8'h3c);
    wait_done();
    chk_val({7'h00, o_ext_int6}, 8'h01);
    chk_reg(16'hff95, 8'h0c);
    chk_reg(16'hff85, 8'h01);
    chk_val(got_a, 8'ha4);
    chk_val(got0, 8'h3c);
    chk_val(got1, 8'hc5);
    // two-byte read
    wr(16'hff80, 8'ha5);
    wr(16'hff85, 8'h03);
    chk_reg(16'hff85, 8'h03);
    chk_val({7'h00, o_ext_int6}, 8'h00);
    wait_done();
    chk_reg(16'hff83, 8'h96);
    chk_reg(16'hff84, 8'h5a);
    // one-byte read with the enable off
    wr(16'hff95, 8'h00);
    rd0 = 8'h3b;
    wr(16'hff85, 8'h02);
    wait_done();
    chk_val({7'h00, o_ext_int6}, 8'h00);
    chk_reg(16'hff95, 8'h04);
    chk_reg(16'hff83, 8'h3b);
    // address refused by the slave, then a clean retry
    nack = 1'b1;
    wr(16'hff80, 8'ha4);
    wr(16'hff81, 8'he1);
    wr(16'hff85, 8'h02);
    wait_done();
    chk_reg(16'hff85, 8'h04);
    nack = 1'b0;
    wr(16'hff85, 8'h02);
    chk_reg(16'hff85, 8'h02);
    wait_done();
    chk_val(got0, 8'he1);
    chk_reg(16'hff85, 8'h00);
    end_of_test();
  end
endmodule : serial_two_wire_master_tb_top

/* sim/two_wire_slave_model.sv */
// behavioural bus slave: acks, captures writes, returns read bytes
`timescale 1ns/1ps
module two_wire_slave_model (
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_nack,
  input  wire logic [7:0] i_rd0,
  input  wire logic [7:0] i_rd1,
  output logic            o_sda_oe_n,
  output logic [7:0]      o_got_addr,
  output logic [7:0]      o_got0,
  output logic [7:0]      o_got1
);
  int         bit_n = 99;
  int         byte_n = 0;
  logic       mnack = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] rdb;
  initial o_sda_oe_n = 1'b1;
  // start and stop seen while clock is high
  always @(negedge i_sda) if (i_scl) begin
    bit_n = -1;
    byte_n = 0;
    mnack = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) bit_n = 99;
  // shift in data, note master nack on read
  always @(posedge i_scl) begin
    if (bit_n >= 0 && bit_n < 8) sh = {sh[6:0], i_sda};
    if (bit_n == 8 && byte_n > 0 && i_sda) mnack = 1'b1;
  end
  // advance and set up the next bit while clock is low
  always @(negedge i_scl) if (bit_n < 99) begin
    bit_n = bit_n + 1;
    if (bit_n == 9) begin
      bit_n = 0;
      byte_n++;
    end
    if (bit_n == 8 && byte_n == 0) o_got_addr = sh;
    if (bit_n == 8 && byte_n == 1 && !o_got_addr[0]) o_got0 = sh;
    if (bit_n == 8 && byte_n == 2 && !o_got_addr[0]) o_got1 = sh;
    rdb = (byte_n == 1) ? i_rd0 : i_rd1;
    if (bit_n == 8) o_sda_oe_n = (byte_n == 0) ? i_nack : o_got_addr[0];
    else if (o_got_addr[0] && byte_n > 0 && byte_n < 3 && !mnack)
      o_sda_oe_n = rdb[7-bit_n];
    else o_sda_oe_n = 1'b1;
  end
endmodule : two_wire_slave_model
